// ---- verilog/phy_strap_config.sv ----
// Reset-time strap latch, configuration registers and MII qualification
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Sample all straps once after reset release; hold them until the next reset.
// - Strap pins stay undriven inputs during reset, then drive their normal function.
// - Catch a three-bit management address, any value, default one from pulls.
// - Upper two management address bits are always zero.
// - Address zero is broadcast unless strap or software bit nine makes it unique.
// - Address-zero-unique strap high makes address zero unique; low keeps broadcast.
// - Decode configuration straps: 000 normal MII, 110 back-to-back, rest reserved.
// - Wake output enable strap goes into PHY control bit fifteen.
// - Isolate strap goes into control bit ten.
// - Speed strap sets control bit thirteen and the advertised 100 Mbps abilities.
// - Duplex strap high means half duplex, reflected in control bit eight.
// - Auto-negotiation strap goes into control bit twelve.
// - Receive nibble is driven on the clock and valid only with its valid flag.
// - In EEE mode the transmit error input requests low-power idle.
module phy_strap_config
  import phy_strap_pkg::*;
(
  input  wire logic                        pclk,         // 40 MHz clock
  input  wire logic                        presetn,      // Async reset, active low
  // APB slave
  input  wire logic                        psel,         // Select
  input  wire logic                        penable,      // Access phase
  input  wire logic                        pwrite,       // Write when high
  input  wire logic [phy_strap_pkg::ADDR_W-1:0] paddr,   // Byte address
  input  wire logic [31:0]                 pwdata,       // Write data
  input  wire logic [3:0]                  pstrb,        // Byte lane strobes
  output logic [31:0]                      prdata,       // Read data
  output logic                             pready,       // Transfer done
  output logic                             pslverr,      // Unmapped address
  // Shared strap pins
  input  wire logic [phy_strap_pkg::STRAP_W-1:0] pin_in,  // Pin level
  output logic [phy_strap_pkg::STRAP_W-1:0] pin_out,     // Pin drive value
  output logic [phy_strap_pkg::STRAP_W-1:0] pin_oe,      // High while driving
  input  wire logic [phy_strap_pkg::STRAP_W-1:0] func_out, // Normal pin function
  // MII receive side
  input  wire logic [3:0]                  core_rx_nibble, // Decoded nibble
  input  wire logic                        core_rx_valid,  // Nibble valid
  output logic [3:0]                       mii_rxd,      // Receive data
  output logic                             mii_rxdv,     // Receive data valid
  // MII transmit side
  input  wire logic [3:0]                  mii_txd,      // Transmit data
  input  wire logic                        mii_txen,     // Transmit enable
  input  wire logic                        mii_txer,     // Transmit error / LPI
  output logic [3:0]                       core_tx_nibble, // Nibble to encoder
  output logic                             core_tx_valid,  // Nibble valid
  output logic                             tx_lpi,       // Transmit in LPI
  // Effective configuration
  output logic                             config_done,  // Straps caught
  output logic [4:0]                       mgmt_addr,    // Management address
  output logic                             addr0_broadcast, // Address 0 broadcast
  output logic                             mode_mii,     // Normal MII
  output logic                             mode_b2b,     // Back-to-back repeater
  output logic                             mode_reserved, // Reserved code strapped
  output logic                             wake_out_en,  // Wake output enabled
  output logic                             isolate,      // Isolate mode
  output logic                             speed_100,    // 100 Mbps selected
  output logic                             full_duplex,  // Full duplex selected
  output logic                             autoneg_en    // Auto-negotiation on
);

  typedef struct packed {
    phase_t             phase;
    logic [2:0]         cnt;
    logic               run_q;
    logic [STRAP_W-1:0] caught;
    logic [15:0]        ctrl;
    logic [15:0]        adv;
    logic [15:0]        phyctl;
    logic               eee_en;
    logic [31:0]        rdata;
    logic [STRAP_W-1:0] pout;
    logic [3:0]         rxd;
    logic               rxdv;
    logic [3:0]         txd;
    logic               txv;
    logic               lpi;
  } cfg_t;

  localparam cfg_t CFG_RST = '{
    phase:  PH_SETTLE,
    cnt:    3'h0,
    run_q:  1'b0,
    caught: STRAP_PULL,
    ctrl:   CTRL_RST,
    adv:    ADV_RST,
    phyctl: PHYCTL_RST,
    eee_en: 1'b0,
    rdata:  32'h0000_0000,
    pout:   '0,
    rxd:    4'h0,
    rxdv:   1'b0,
    txd:    4'h0,
    txv:    1'b0,
    lpi:    1'b0
  };

  cfg_t st;
  cfg_t next_st;

  strap_if sbus ();

  // Pin synchroniser and agreement filter
  strap_sampler u_sampler (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (pin_in),
    .sbus    (sbus.sampler)
  );

  // Bus decode
  logic        acc;
  logic        wr_en;
  logic        hit;
  logic [9:0]  idx;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic [15:0] strap_view;
  logic [15:0] rmux;
  logic [2:0]  cfg_code;

  assign idx   = paddr[11:2];
  assign acc   = psel && penable;
  assign wval  = pwdata[15:0];
  assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign hit   = (idx == IDX_CTRL) || (idx == IDX_ADV) || (idx == IDX_PHYCTL) ||
                 (idx == IDX_STRAP) || (idx == IDX_EEE);
  // Writes land only once the straps are in, so they cannot be overwritten
  assign wr_en = acc && pwrite && st.run_q && hit;

  assign cfg_code = st.caught[SB_CFG_LSB +: 3];

  // Read-only view of the caught straps and decoded mode
  always_comb begin
    strap_view        = 16'h0000;
    strap_view[2:0]   = st.caught[SB_ADDR_LSB +: 3];
    strap_view[4:3]   = 2'b00;
    strap_view[7:5]   = cfg_code;
    strap_view[8]     = mode_b2b;
    strap_view[9]     = mode_reserved;
    strap_view[10]    = st.caught[SB_ADDR0U];
    strap_view[11]    = addr0_broadcast;
    // Phase, not run_q: a read stalled over start-up loads here one edge before it completes
    strap_view[12]    = (st.phase == PH_RUN);
  end

  // Read multiplexer; unmapped words read as zero
  always_comb begin
    case (idx)
      IDX_CTRL:   rmux = st.ctrl;
      IDX_ADV:    rmux = st.adv;
      IDX_PHYCTL: rmux = st.phyctl;
      IDX_STRAP:  rmux = strap_view;
      IDX_EEE:    rmux = {15'h0000, st.eee_en};
      default:    rmux = 16'h0000;
    endcase
  end

  // Next-state logic for start-up, registers and MII paths
  always_comb begin
    next_st = st;
    // Start-up sequence after reset release
    case (st.phase)
      PH_SETTLE: begin
        // Give the filter time to see the pins with the pulls alone
        if (st.cnt == SETTLE_CYC - 3'h1) begin
          next_st.phase = PH_LATCH;
        end else begin
          next_st.cnt = st.cnt + 3'h1;
        end
      end
      PH_LATCH: begin
        next_st.caught = sbus.level;
        next_st.phase  = PH_RUN;
        // Load the control bits from the pins
        next_st.ctrl[CTRL_SPEED] = sbus.level[SB_SPEED];
        next_st.ctrl[CTRL_ANEN]  = sbus.level[SB_AUTONEG];
        next_st.ctrl[CTRL_ISO]   = sbus.level[SB_ISO];
        next_st.ctrl[CTRL_FDX]   = !sbus.level[SB_DUPLEX];
        // Advertise 100 Mbps only when strapped for it
        next_st.adv[ADV_100FD]   = sbus.level[SB_SPEED];
        next_st.adv[ADV_100HD]   = sbus.level[SB_SPEED];
        next_st.adv[ADV_10FD]    = 1'b1;
        next_st.adv[ADV_10HD]    = 1'b1;
        next_st.phyctl[PHYCTL_WAKE] = sbus.level[SB_WAKE];
      end
      PH_RUN: begin
        next_st.run_q = 1'b1;
      end
      default: begin
        next_st.phase = PH_SETTLE;
        next_st.cnt   = 3'h0;
      end
    endcase

    // Register writes after the catch replace strap-loaded bits
    if (wr_en) begin
      case (idx)
        IDX_CTRL:   next_st.ctrl   = (st.ctrl & ~wmask) | (wval & wmask);
        IDX_ADV:    next_st.adv    = (st.adv & ~wmask) | (wval & wmask);
        IDX_PHYCTL: next_st.phyctl = (st.phyctl & ~wmask) | (wval & wmask);
        IDX_EEE: begin
          if (pstrb[0]) begin
            next_st.eee_en = pwdata[EEE_EN];
          end
        end
        default: begin
          next_st.eee_en = st.eee_en;
        end
      endcase
    end

    // Read data tracks the bus until the completing edge
    if (psel && !(penable && pready)) begin
      next_st.rdata = {16'h0000, rmux};
    end

    // Normal pin function, registered before it reaches the pads
    next_st.pout = func_out;

    // Receive nibble is cleared outside valid data
    next_st.rxdv = core_rx_valid;
    next_st.rxd  = core_rx_valid ? core_rx_nibble : 4'h0;

    // Transmit nibble is taken as data whenever enable is high
    next_st.txv = mii_txen;
    next_st.txd = mii_txen ? mii_txd : 4'h0;

    // Outside EEE mode the error input is ignored entirely
    next_st.lpi = st.eee_en && mii_txer;
  end

  // State register; constants only under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= CFG_RST;
    end else begin
      st <= next_st;
    end
  end

  // APB answers; a one-cycle gap after the catch keeps reads coherent
  assign pready  = st.run_q;
  assign pslverr = acc && st.run_q && !hit;
  assign prdata  = st.rdata;

  // Pads float on their pulls until the catch is done
  assign pin_oe  = {STRAP_W{st.phase == PH_RUN}};
  assign pin_out = st.pout;

  // MII outputs from flops
  assign mii_rxd        = st.rxd;
  assign mii_rxdv       = st.rxdv;
  assign core_tx_nibble = st.txd;
  assign core_tx_valid  = st.txv;
  assign tx_lpi         = st.lpi;

  // Effective configuration from registered state
  assign config_done     = st.run_q;
  assign mgmt_addr       = {2'b00, st.caught[SB_ADDR_LSB +: 3]};
  // Either source makes address zero unique
  assign addr0_broadcast = !(st.caught[SB_ADDR0U] || st.phyctl[PHYCTL_A0U]);
  assign mode_mii        = (cfg_code == CFG_MII);
  assign mode_b2b        = (cfg_code == CFG_B2B);
  // Reserved codes are flagged only; the core treats them as unsupported
  assign mode_reserved   = !mode_mii && !mode_b2b;
  assign wake_out_en     = st.phyctl[PHYCTL_WAKE];
  assign isolate         = st.ctrl[CTRL_ISO];
  assign speed_100       = st.ctrl[CTRL_SPEED];
  assign full_duplex     = st.ctrl[CTRL_FDX];
  assign autoneg_en      = st.ctrl[CTRL_ANEN];

endmodule : phy_strap_config
`default_nettype wire

// ---- common/phy_strap_pkg.sv ----
// Constants, field layouts and reset values for the strap configuration latch
package phy_strap_pkg;

  // Strap bank layout, one bit per shared pin
  localparam int STRAP_W      = 12;
  localparam int SB_ADDR_LSB  = 0;   // Three management address bits
  localparam int SB_CFG_LSB   = 3;   // Three interface configuration bits
  localparam int SB_WAKE      = 6;
  localparam int SB_ISO       = 7;
  localparam int SB_SPEED     = 8;
  localparam int SB_DUPLEX    = 9;
  localparam int SB_AUTONEG   = 10;
  localparam int SB_ADDR0U    = 11;

  // Levels the internal pulls give an unconnected pin
  localparam logic [STRAP_W-1:0] STRAP_PULL = 12'h0701;

  // Cycles to wait after reset release before the catch
  localparam logic [2:0] SETTLE_CYC = 3'h4;

  // APB geometry; byte address is four times the register index
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_CTRL   = 10'h000;
  localparam logic [9:0] IDX_ADV    = 10'h004;
  localparam logic [9:0] IDX_PHYCTL = 10'h016;
  localparam logic [9:0] IDX_STRAP  = 10'h020;
  localparam logic [9:0] IDX_EEE    = 10'h021;

  // Control register fields
  localparam int CTRL_SPEED = 13;
  localparam int CTRL_ANEN  = 12;
  localparam int CTRL_ISO   = 10;
  localparam int CTRL_FDX   = 8;
  // Advertisement register fields
  localparam int ADV_100FD  = 8;
  localparam int ADV_100HD  = 7;
  localparam int ADV_10FD   = 6;
  localparam int ADV_10HD   = 5;
  // PHY control register fields
  localparam int PHYCTL_WAKE = 15;
  localparam int PHYCTL_A0U  = 9;
  // EEE control register field
  localparam int EEE_EN      = 0;

  // Reset values, matching the pull defaults
  localparam logic [15:0] CTRL_RST   = 16'h3000;
  localparam logic [15:0] ADV_RST    = 16'h01e1;
  localparam logic [15:0] PHYCTL_RST = 16'h0000;

  // Interface configuration codes
  localparam logic [2:0] CFG_MII = 3'h0;
  localparam logic [2:0] CFG_B2B = 3'h6;

  // Start-up phases
  typedef enum logic [2:0] {
    PH_SETTLE = 3'b001,
    PH_LATCH  = 3'b010,
    PH_RUN    = 3'b100
  } phase_t;

endpackage : phy_strap_pkg

// ---- common/strap_if.sv ----
// Carrier for the filtered strap levels between sampler and latch
`timescale 1ns/10ps
`default_nettype none
interface strap_if;
  logic [phy_strap_pkg::STRAP_W-1:0] level; // Filtered pin levels
  modport sampler (output level);
  modport user    (input  level);
endinterface : strap_if
`default_nettype wire

// ---- verilog/strap_sampler.sv ----
// Three-stage synchroniser and agreement filter for the strap pins
`timescale 1ns/10ps
`default_nettype none
module strap_sampler
  import phy_strap_pkg::*;
(
  input  wire logic                pclk,    // Clock
  input  wire logic                presetn, // Async reset, active low
  input  wire logic [STRAP_W-1:0]  pin_in,  // Raw pin levels
  strap_if.sampler                 sbus     // Filtered levels out
);

  typedef struct packed {
    logic [STRAP_W-1:0] s1;
    logic [STRAP_W-1:0] s2;
    logic [STRAP_W-1:0] s3;
    logic [STRAP_W-1:0] level;
  } samp_t;

  localparam samp_t SAMP_RST = '{s1: STRAP_PULL, s2: STRAP_PULL,
                                 s3: STRAP_PULL, level: STRAP_PULL};

  samp_t st;
  samp_t next_st;

  // Shift chain; s1 feeds only s2 so metastability stays in one stage
  always_comb begin
    next_st    = st;
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < STRAP_W; i++) begin
      // A change counts only once stages two and three agree
      if (st.s2[i] == st.s3[i]) begin
        next_st.level[i] = st.s2[i];
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= SAMP_RST;
    end else begin
      st <= next_st;
    end
  end

  assign sbus.level = st.level;

endmodule : strap_sampler
`default_nettype wire

// ---- dv/phy_strap_config_asserts.sv ----
// Checker on the strap configuration latch ports
`timescale 1ns/10ps
`default_nettype none
module phy_strap_config_asserts
  import phy_strap_pkg::*;
(
  input wire logic       pclk,           // Clock
  input wire logic       presetn,        // Reset, active low
  input wire logic       pready,         // Transfer done
  input wire logic       config_done,    // Straps caught
  input wire logic [phy_strap_pkg::STRAP_W-1:0] pin_out,  // Pin drive
  input wire logic [phy_strap_pkg::STRAP_W-1:0] pin_oe,   // Pin enable
  input wire logic [phy_strap_pkg::STRAP_W-1:0] func_out, // Normal function
  input wire logic [3:0] core_rx_nibble, // Rx nibble in
  input wire logic       core_rx_valid,  // Rx valid in
  input wire logic [3:0] mii_rxd,        // Rx nibble out
  input wire logic       mii_rxdv,       // Rx valid out
  input wire logic [3:0] mii_txd,        // Tx nibble in
  input wire logic       mii_txen,       // Tx enable
  input wire logic       mii_txer,       // Tx error or LPI
  input wire logic [3:0] core_tx_nibble, // Tx nibble out
  input wire logic       core_tx_valid,  // Tx valid out
  input wire logic       tx_lpi,         // Tx low-power idle
  input wire logic [4:0] mgmt_addr,      // Management address
  input wire logic       mode_mii,       // Normal MII
  input wire logic       mode_b2b,       // Back to back
  input wire logic       mode_reserved   // Reserved code
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Start-up: pins turn to outputs, then the bus opens a cycle later
  sequence s_oe_on;
    $rose(pin_oe[0]);
  endsequence
  sequence s_open;
    config_done && pready;
  endsequence
  property p_start;
    s_oe_on |=> s_open;
  endproperty
  a_start: assert property (p_start)
    else $error("bus did not open after pins turned");
  property p_oe;
    (pin_oe == '0 || pin_oe == '1) && (!config_done || pin_oe[0]);
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin enables disagree");
  // First driving cycle sees a reset-time enable, so it is skipped
  property p_drive;
    pin_oe[0] && $past(pin_oe[0]) |-> pin_out == $past(func_out);
  endproperty
  a_drive: assert property (p_drive)
    else $error("pin drive not the normal function");
  property p_addr_hi;
    mgmt_addr[4:3] == 2'b00;
  endproperty
  a_addr_hi: assert property (p_addr_hi)
    else $error("upper address bits set");
  property p_mode;
    $onehot({mode_mii, mode_b2b, mode_reserved});
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode decode not one-hot");
  property p_hold;
    config_done && $past(config_done) |-> $stable({mgmt_addr, mode_mii, mode_b2b});
  endproperty
  a_hold: assert property (p_hold)
    else $error("caught strap value moved");
  property p_rx;
    1'b1 |=> mii_rxdv == $past(core_rx_valid)
      && mii_rxd == ($past(core_rx_valid) ? $past(core_rx_nibble) : 4'h0);
  endproperty
  a_rx: assert property (p_rx)
    else $error("receive nibble not qualified");
  property p_tx;
    mii_txen |=> core_tx_valid && core_tx_nibble == $past(mii_txd);
  endproperty
  a_tx: assert property (p_tx)
    else $error("transmit nibble lost");
  property p_lpi;
    !mii_txer |=> !tx_lpi;
  endproperty
  a_lpi: assert property (p_lpi)
    else $error("low-power idle without request");
endmodule : phy_strap_config_asserts
bind phy_strap_config phy_strap_config_asserts chk (
  .pclk(pclk), .presetn(presetn), .pready(pready), .config_done(config_done),
  .pin_out(pin_out), .pin_oe(pin_oe), .func_out(func_out),
  .core_rx_nibble(core_rx_nibble), .core_rx_valid(core_rx_valid),
  .mii_rxd(mii_rxd), .mii_rxdv(mii_rxdv), .mii_txd(mii_txd), .mii_txen(mii_txen),
  .mii_txer(mii_txer), .core_tx_nibble(core_tx_nibble),
  .core_tx_valid(core_tx_valid), .tx_lpi(tx_lpi), .mgmt_addr(mgmt_addr),
  .mode_mii(mode_mii), .mode_b2b(mode_b2b), .mode_reserved(mode_reserved));
`default_nettype wire

// ---- dv/strap_board.sv ----
// Board strap resistors on the shared pins
`timescale 1ns/10ps
`default_nettype none
module strap_board (
  input  wire logic [phy_strap_pkg::STRAP_W-1:0] strap,   // Resistor levels
  input  wire logic [phy_strap_pkg::STRAP_W-1:0] pin_out, // Device drive
  input  wire logic [phy_strap_pkg::STRAP_W-1:0] pin_oe,  // Device enable
  output logic      [phy_strap_pkg::STRAP_W-1:0] pin_in   // Wire level
);
  // Resistor level wins only while the device lets go of the pin
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & strap);
endmodule : strap_board
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the strap configuration latch
`timescale 1ns/10ps
`default_nettype none
module tb;
  import phy_strap_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, core_rx_nibble, mii_rxd, mii_txd, core_tx_nibble;
  logic [STRAP_W-1:0] pin_in, pin_out, pin_oe, func_out, straps;
  logic core_rx_valid, mii_rxdv, mii_txen, mii_txer, core_tx_valid, tx_lpi;
  logic config_done, addr0_broadcast, mode_mii, mode_b2b, mode_reserved;
  logic wake_out_en, isolate, speed_100, full_duplex, autoneg_en;
  logic [4:0] mgmt_addr;
  int num_errors, compares;
  // Pull defaults, then the single-bit straps flipped with address zero and back-to-back, then a reserved code
  logic [STRAP_W-1:0] tbl [3] = '{12'h701, 12'h8f0, 12'h71f};
  localparam logic [11:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] A_ADV  = {IDX_ADV, 2'b00};
  localparam logic [11:0] A_PHY  = {IDX_PHYCTL, 2'b00};
  localparam logic [11:0] A_VIEW = {IDX_STRAP, 2'b00};

  phy_strap_config dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .func_out(func_out),
    .core_rx_nibble(core_rx_nibble), .core_rx_valid(core_rx_valid),
    .mii_rxd(mii_rxd), .mii_rxdv(mii_rxdv), .mii_txd(mii_txd),
    .mii_txen(mii_txen), .mii_txer(mii_txer), .core_tx_nibble(core_tx_nibble),
    .core_tx_valid(core_tx_valid), .tx_lpi(tx_lpi), .config_done(config_done),
    .mgmt_addr(mgmt_addr), .addr0_broadcast(addr0_broadcast),
    .mode_mii(mode_mii), .mode_b2b(mode_b2b), .mode_reserved(mode_reserved),
    .wake_out_en(wake_out_en), .isolate(isolate), .speed_100(speed_100),
    .full_duplex(full_duplex), .autoneg_en(autoneg_en));
  strap_board board (.strap(straps), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in));

  // Clock, 25 ns period
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; entered just after a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    if (n >= 200) begin
      num_errors++;
      $display("mismatch at %0t: no pready", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rdc(input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0000_0000, er}, {31'h0000_0000, e});
  endtask : rdc

  // Expected register images, worked out from the strap levels
  function automatic logic [31:0] ex_ctrl(input logic [11:0] s);
    return {18'h0_0000, s[SB_SPEED], s[SB_AUTONEG], 1'b0, s[SB_ISO], 1'b0,
            ~s[SB_DUPLEX], 8'h00};
  endfunction : ex_ctrl
  function automatic logic [31:0] ex_view(input logic [11:0] s);
    logic [2:0] c;
    c = s[5:3];
    return {19'h0_0000, 1'b1, ~s[11], s[11], c != 3'h0 && c != 3'h6,
            c == 3'h6, c, 2'b00, s[2:0]};
  endfunction : ex_view

  task endt(input string name);
    $display("test %0s done", name);
  endtask : endt

  // Reset with given straps, check the catch, then move the pins
  task boot(input logic [11:0] s);
    straps <= s;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({20'h0_0000, pin_oe}, 32'h0000_0000);
    presetn <= 1'b1;
    rdc(A_VIEW, ex_view(s), 1'b0);
    chk({23'h00_0000, mgmt_addr, mode_mii, mode_b2b, mode_reserved, addr0_broadcast},
        {23'h00_0000, 2'b00, s[2:0], s[5:3] == 3'h0, s[5:3] == 3'h6,
         s[5:3] != 3'h0 && s[5:3] != 3'h6, ~s[11]});
    chk({26'h000_0000, config_done, wake_out_en, isolate, speed_100, full_duplex, autoneg_en},
        {26'h000_0000, 1'b1, s[6], s[7], s[8], ~s[9], s[10]});
    rdc(A_CTRL, ex_ctrl(s), 1'b0);
    rdc(A_ADV, {23'h00_0000, s[8], s[8], 7'h61}, 1'b0);
    rdc(A_PHY, {16'h0000, s[6], 15'h0000}, 1'b0);
    func_out <= ~s;
    repeat (8) @(posedge pclk);
    rdc(A_VIEW, ex_view(s), 1'b0);
    chk({20'h0_0000, pin_out}, {20'h0_0000, ~s});
    endt("boot");
  endtask : boot

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, core_rx_valid, mii_txen, mii_txer} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    {core_rx_nibble, mii_txd} = 8'h00;
    func_out = 12'ha5a;
    straps = tbl[0];
    num_errors = 0;
    compares = 0;
    @(posedge pclk);
    for (int i = 0; i < 3; i++) begin
      boot(tbl[i]);
    end
    // Software overrides of strap-loaded bits
    apb(1'b1, A_CTRL, 32'h0000_0100);
    chk({29'h0000_0000, speed_100, full_duplex, autoneg_en}, 32'h0000_0002);
    rdc(A_CTRL, 32'h0000_0100, 1'b0);
    apb(1'b1, A_PHY, 32'h0000_8200);
    chk({30'h0000_0000, wake_out_en, addr0_broadcast}, 32'h0000_0002);
    apb(1'b1, A_VIEW, 32'hffff_ffff);
    rdc(A_VIEW, ex_view(tbl[2]) ^ 32'h0000_0800, 1'b0);
    apb(1'b1, 12'h0fc, 32'h0000_1234);
    rdc(12'h0fc, 32'h0000_0000, 1'b1);
    endt("override");
    // LPI request ignored until the energy-efficient mode is on
    mii_txer <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({31'h0000_0000, tx_lpi}, 32'h0000_0000);
    apb(1'b1, {IDX_EEE, 2'b00}, 32'h0000_0001);
    @(posedge pclk);
    chk({31'h0000_0000, tx_lpi}, 32'h0000_0001);
    mii_txer <= 1'b0;
    // Nibble traffic both ways, valid toggling
    for (int i = 0; i < 16; i++) begin
      core_rx_nibble <= 4'(i);
      core_rx_valid <= i[0];
      mii_txd <= ~4'(i);
      mii_txen <= i[1];
      @(posedge pclk);
    end
    // Inputs held one more edge so the last nibble stands while it is looked at
    @(posedge pclk);
    chk({22'h00_0000, mii_rxdv, mii_rxd, core_tx_valid, core_tx_nibble},
        {22'h00_0000, 1'b1, 4'hf, 1'b1, 4'h0});
    core_rx_valid <= 1'b0;
    mii_txen <= 1'b0;
    @(posedge pclk);
    endt("mii");
    boot(tbl[0]);
    conclude();
  end

  // Watchdog well past the expected few hundred cycles
  initial begin
    #(25 * 20000);
    num_errors++;
    $display("mismatch at %0t: watchdog", $time);
    conclude();
  end

  task conclude;
    $display("counts: %0d compares, %0d mismatches", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
endmodule : tb
`default_nettype wire
